// ===== csvr_clk_status.sv
// clock detection flag collector for the read-only status bits
// assumes detector inputs come from logic on the core clock
`timescale 1ns/1ps
module csvr_clk_status
  import csvr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  csvr_core_if.stat bus
);
  logic [5:0] flags_reg, flags_next;
  logic ratio_ok;

  assign ratio_ok = bus.bck_ratio_stable && (bus.bck_ratio >= BCK_RATIO_MIN) &&
                    (bus.bck_ratio <= BCK_RATIO_MAX);
  assign bus.flags = flags_reg;

  // flags follow the detectors, one cycle late
  always_comb begin
    flags_next = 6'h00;
    flags_next[FLAG_BCLK_RATE] = bus.bclk_rate_err;
    flags_next[FLAG_PLL_OVER] = bus.pll_overrate;
    flags_next[FLAG_PLL_LOCK] = bus.pll_locked && bus.pll_enabled;
    flags_next[FLAG_BCK_MISSING] = bus.bck_missing;
    flags_next[FLAG_BCK_VALID] = ratio_ok;
    // no ignore input here: the flag must show even when errors are ignored
    if (bus.fs_mode == FS_MODE_AUTO) begin
      flags_next[FLAG_FS] = (bus.fs_detected != FS_DET_ERROR);
    end else begin
      flags_next[FLAG_FS] = (bus.fs_mode != bus.fs_detected);
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_reg <= RST_CLK_FLAGS[5:0];
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule

// ===== csvr_core_if.sv
// bundle between the register top and its ramp engine and status collector
// assumes all members run on the core clock
`timescale 1ns/1ps
interface csvr_core_if;
  logic fs_tick;
  logic [7:0] target_code;
  logic [7:0] ramp_cfg;
  logic [7:0] cur_code;
  logic bclk_rate_err;
  logic pll_overrate;
  logic pll_locked;
  logic pll_enabled;
  logic bck_missing;
  logic [9:0] bck_ratio;
  logic bck_ratio_stable;
  logic [3:0] fs_mode;
  logic [3:0] fs_detected;
  logic [5:0] flags;
  modport ramp (input fs_tick, input target_code, input ramp_cfg, output cur_code);
  modport stat (input bclk_rate_err, input pll_overrate, input pll_locked, input pll_enabled,
                input bck_missing, input bck_ratio, input bck_ratio_stable, input fs_mode,
                input fs_detected, output flags);
  modport top (output fs_tick, output target_code, output ramp_cfg, input cur_code,
               output bclk_rate_err, output pll_overrate, output pll_locked, output pll_enabled,
               output bck_missing, output bck_ratio, output bck_ratio_stable, output fs_mode,
               output fs_detected, input flags);
endinterface

// ===== csvr_pkg.sv
// constants shared by the clock status, hi-z and volume ramp register block
// assumes an i2c control port and a one-cycle sample-rate tick from the audio path
// What this block does
// - Status bit 5 reports serial bit clock overrate or underrate, read only.
// - Status bit 4 reports internal phase-locked loop overrate, read only.
// - Status bit 3 shows loop lock; disabled loop reads as unlocked.
// - Status bit 2 flags a missing serial bit clock, read only.
// - Status bit 1: bit clock valid when ratio stable and within 32 to 512.
// - Status bit 0: rate valid in auto mode, else configured/detected mismatch.
// - Rate error flag still asserts when rate errors are set to be ignored.
// - Hi-z bit 4 set floats left output; clear hands it back to state control.
// - Hi-z bit 3 set floats right output; clear hands it back to state control.
// - A forced channel leaves hi-z only when software clears its force bit or bridged mono mode is set.
// - Both force bits are ignored in bridged mono output mode.
// - One 8-bit volume code sets both channels: 0 is +24 dB, 0.5 dB steps.
// - Ramp down updates every 1, 2 or 4 sample periods; code 11 jumps.
// - Each ramp-down update lowers gain by 4, 2, 1 or 0.5 dB.
// - Ramp up updates every 1, 2 or 4 sample periods; code 11 restores at once.
// - Each ramp-up update raises gain by 4, 2, 1 or 0.5 dB.
package csvr_pkg;
  // register offsets on the control port
  localparam logic [7:0] ADDR_CLK_FLAGS = 8'h39;
  localparam logic [7:0] ADDR_HIZ_FORCE = 8'h40;
  localparam logic [7:0] ADDR_VOLUME = 8'h4C;
  localparam logic [7:0] ADDR_RAMP_CFG = 8'h4E;
  // reset values
  localparam logic [7:0] RST_CLK_FLAGS = 8'h00;
  localparam logic [7:0] RST_HIZ_FORCE = 8'h01;
  localparam logic [7:0] RST_VOLUME = 8'h30;
  localparam logic [7:0] RST_RAMP_CFG = 8'h33;
  // field positions
  localparam int BIT_LEFT_FLOAT = 4;
  localparam int BIT_RIGHT_FLOAT = 3;
  localparam int DOWN_IVL_LSB = 6;
  localparam int DOWN_INC_LSB = 4;
  localparam int UP_IVL_LSB = 2;
  localparam int UP_INC_LSB = 0;
  localparam logic [7:0] CLK_FLAGS_RW_MASK = 8'hC0;
  localparam int FLAG_BCLK_RATE = 5;
  localparam int FLAG_PLL_OVER = 4;
  localparam int FLAG_PLL_LOCK = 3;
  localparam int FLAG_BCK_MISSING = 2;
  localparam int FLAG_BCK_VALID = 1;
  localparam int FLAG_FS = 0;
  // bit clock ratio limits in sample periods
  localparam logic [9:0] BCK_RATIO_MIN = 10'h020;
  localparam logic [9:0] BCK_RATIO_MAX = 10'h200;
  localparam logic [3:0] FS_MODE_AUTO = 4'h0;
  localparam logic [3:0] FS_DET_ERROR = 4'h0;
  // volume coding: one code per 0.5 dB
  localparam logic [7:0] VOL_MUTE_CODE = 8'hFF;
  localparam logic [1:0] IVL_JUMP = 2'h3;
  // i2c framing
  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C; // arbitrary value
  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_PTR, I2C_ACK_PTR,
                I2C_WDATA, I2C_ACK_WR, I2C_RDATA, I2C_ACK_RD} csvr_i2c_e;
endpackage

// ===== csvr_regs_asserts.sv
// port-level checker for the clock status, hi-z and volume ramp register block
// assumes the core clock and synchronous active-high reset of the top module
`timescale 1ns/1ps
module csvr_regs_asserts
  import csvr_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic MUTE_REQ_I,
  input wire logic BRIDGED_MONO_MODE_I,
  input wire logic LEFT_HIZ_O,
  input wire logic RIGHT_HIZ_O,
  input wire logic [7:0] VOLUME_CODE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // open drain: only the enable may ever carry data
  property p_sda_low; SDA_O == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda output not held low");
  // an ack or data bit is launched or released only while the clock line is low
  property p_oe_rise; $changed(SDA_OE_O) |-> !SCL_I; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("sda enable moved while scl high");
  property p_left_mono; BRIDGED_MONO_MODE_I |=> !LEFT_HIZ_O; endproperty
  a_left_mono: assert property (p_left_mono) else $error("left float in bridged mode");
  property p_right_mono; BRIDGED_MONO_MODE_I |=> !RIGHT_HIZ_O; endproperty
  a_right_mono: assert property (p_right_mono) else $error("right float in bridged mode");
  // first edge after release still shows the reset state
  property p_reset_vals;
    $fell(SRST_I) |-> VOLUME_CODE_O == RST_VOLUME && !LEFT_HIZ_O && !RIGHT_HIZ_O && !SDA_OE_O;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset state");
  // muted target is the top code, so the live code may only climb
  property p_mute_rise; MUTE_REQ_I [*3] |=> VOLUME_CODE_O >= $past(VOLUME_CODE_O); endproperty
  a_mute_rise: assert property (p_mute_rise) else $error("volume rose while muted");
  property p_mute_hold; MUTE_REQ_I [*3] ##0 VOLUME_CODE_O == VOL_MUTE_CODE |=> VOLUME_CODE_O == VOL_MUTE_CODE;
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("volume left target");
  // no bus traffic, no mode change: the float outputs must not move
  property p_hiz_quiet;
    (SCL_I && !BRIDGED_MONO_MODE_I) [*8] |=> $stable(LEFT_HIZ_O) && $stable(RIGHT_HIZ_O);
  endproperty
  a_hiz_quiet: assert property (p_hiz_quiet) else $error("float output moved by itself");
endmodule

bind csvr_regs_top csvr_regs_asserts chk_u (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .MUTE_REQ_I(MUTE_REQ_I), .BRIDGED_MONO_MODE_I(BRIDGED_MONO_MODE_I),
  .LEFT_HIZ_O(LEFT_HIZ_O), .RIGHT_HIZ_O(RIGHT_HIZ_O), .VOLUME_CODE_O(VOLUME_CODE_O));

// ===== csvr_regs_top.sv
// register bank top: i2c slave, status, hi-z force and shared volume ramp
// assumes scl/sda arrive asynchronously as separate in/out/enable pins
`timescale 1ns/1ps
module csvr_regs_top
  import csvr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)(
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic FS_TICK_I,
  input wire logic MUTE_REQ_I,
  input wire logic BRIDGED_MONO_MODE_I,
  input wire logic BCLK_RATE_ERR_I,
  input wire logic PLL_OVERRATE_I,
  input wire logic PLL_LOCKED_I,
  input wire logic PLL_ENABLED_I,
  input wire logic BCK_MISSING_I,
  input wire logic [9:0] BCK_RATIO_I,
  input wire logic BCK_RATIO_STABLE_I,
  input wire logic [3:0] FS_MODE_I,
  input wire logic [3:0] FS_DETECTED_I,
  output logic LEFT_HIZ_O,
  output logic RIGHT_HIZ_O,
  output logic [7:0] VOLUME_CODE_O
);
  csvr_core_if core ();

  // pin synchronisers and edge history
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // i2c engine state
  csvr_i2c_e st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic oe_reg, oe_next;

  // register bank
  logic [7:0] hiz_reg, hiz_next;
  logic [7:0] vol_reg, vol_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [1:0] flags_hi_reg, flags_hi_next;
  logic wr_en;
  logic [7:0] rd_byte;

  // output flops
  logic left_hiz_reg, left_hiz_next;
  logic right_hiz_reg, right_hiz_next;

  // mapped offsets, shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CLK_FLAGS) || (a == ADDR_HIZ_FORCE) ||
                (a == ADDR_VOLUME) || (a == ADDR_RAMP_CFG);
  endfunction

  // two flops per pin, then a third stage for edges
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= SCL_I;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;

  // read data mux; unmapped offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (!is_mapped(ptr_reg)) begin
      rd_byte = 8'h00;
    end else if (ptr_reg == ADDR_CLK_FLAGS) begin
      rd_byte = {flags_hi_reg, core.flags};
    end else if (ptr_reg == ADDR_HIZ_FORCE) begin
      rd_byte = hiz_reg;
    end else if (ptr_reg == ADDR_VOLUME) begin
      rd_byte = vol_reg;
    end else begin
      rd_byte = cfg_reg;
    end
  end

  // i2c byte engine: sample on scl rise, change sda on scl fall
  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    if (bus_stop) begin
      st_next = I2C_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      // a repeated start keeps the pointer for the read that follows
      st_next = I2C_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      case (st_reg)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          sh_next = {sh_reg[6:0], sda_s2};
          bit_next = bit_reg + 4'h1;
        end
        I2C_ACK_RD: begin
          // master nack ends the read burst
          if (sda_s2) begin
            st_next = I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_reg)
        I2C_ADDR: begin
          if (bit_reg == I2C_BITS) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              st_next = I2C_ACK_ADDR;
              rw_next = sh_reg[0];
              oe_next = 1'b1;
            end else begin
              st_next = I2C_IDLE;
            end
          end
        end
        I2C_ACK_ADDR: begin
          bit_next = 4'h0;
          if (rw_reg) begin
            st_next = I2C_RDATA;
            sh_next = rd_byte;
            oe_next = !rd_byte[7];
          end else begin
            st_next = I2C_PTR;
            oe_next = 1'b0;
          end
        end
        I2C_PTR: begin
          if (bit_reg == I2C_BITS) begin
            ptr_next = sh_reg;
            st_next = I2C_ACK_PTR;
            oe_next = 1'b1;
          end
        end
        I2C_WDATA: begin
          if (bit_reg == I2C_BITS) begin
            wr_en = 1'b1;
            ptr_next = ptr_reg + 8'h01;
            st_next = I2C_ACK_WR;
            oe_next = 1'b1;
          end
        end
        I2C_ACK_PTR, I2C_ACK_WR: begin
          st_next = I2C_WDATA;
          bit_next = 4'h0;
          oe_next = 1'b0;
        end
        I2C_RDATA: begin
          if (bit_reg == I2C_BITS - 4'h1) begin
            st_next = I2C_ACK_RD;
            oe_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
          end else begin
            bit_next = bit_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = !sh_reg[6];
          end
        end
        I2C_ACK_RD: begin
          // still here after the ack bit: master wants another byte
          st_next = I2C_RDATA;
          bit_next = 4'h0;
          sh_next = rd_byte;
          oe_next = !rd_byte[7];
        end
        default: begin
        end
      endcase
    end
  end

  // register bank writes; nothing but a write changes the force bits
  always_comb begin
    hiz_next = hiz_reg;
    vol_next = vol_reg;
    cfg_next = cfg_reg;
    flags_hi_next = flags_hi_reg;
    if (wr_en) begin
      if (!is_mapped(ptr_reg)) begin
        hiz_next = hiz_reg;
      end else if (ptr_reg == ADDR_CLK_FLAGS) begin
        flags_hi_next = sh_reg[7:6] & CLK_FLAGS_RW_MASK[7:6];
      end else if (ptr_reg == ADDR_HIZ_FORCE) begin
        hiz_next = sh_reg;
      end else if (ptr_reg == ADDR_VOLUME) begin
        vol_next = sh_reg;
      end else begin
        cfg_next = sh_reg;
      end
    end
  end

  // channel float outputs, masked in bridged mono
  always_comb begin
    left_hiz_next = hiz_reg[BIT_LEFT_FLOAT] && !BRIDGED_MONO_MODE_I;
    right_hiz_next = hiz_reg[BIT_RIGHT_FLOAT] && !BRIDGED_MONO_MODE_I;
  end

  // all state registers except the pin synchronisers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_reg <= I2C_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      hiz_reg <= RST_HIZ_FORCE;
      vol_reg <= RST_VOLUME;
      cfg_reg <= RST_RAMP_CFG;
      flags_hi_reg <= RST_CLK_FLAGS[7:6];
      left_hiz_reg <= 1'b0;
      right_hiz_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      hiz_reg <= hiz_next;
      vol_reg <= vol_next;
      cfg_reg <= cfg_next;
      flags_hi_reg <= flags_hi_next;
      left_hiz_reg <= left_hiz_next;
      right_hiz_reg <= right_hiz_next;
    end
  end

  // open drain: only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = oe_reg;
  assign LEFT_HIZ_O = left_hiz_reg;
  assign RIGHT_HIZ_O = right_hiz_reg;
  assign VOLUME_CODE_O = core.cur_code;

  // feed the sub-blocks; mute drives the ramp toward zero volume
  assign core.fs_tick = FS_TICK_I;
  assign core.target_code = MUTE_REQ_I ? VOL_MUTE_CODE : vol_reg;
  assign core.ramp_cfg = cfg_reg;
  assign core.bclk_rate_err = BCLK_RATE_ERR_I;
  assign core.pll_overrate = PLL_OVERRATE_I;
  assign core.pll_locked = PLL_LOCKED_I;
  assign core.pll_enabled = PLL_ENABLED_I;
  assign core.bck_missing = BCK_MISSING_I;
  assign core.bck_ratio = BCK_RATIO_I;
  assign core.bck_ratio_stable = BCK_RATIO_STABLE_I;
  assign core.fs_mode = FS_MODE_I;
  assign core.fs_detected = FS_DETECTED_I;

  csvr_vol_ramp u_ramp (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .bus(core.ramp)
  );

  csvr_clk_status u_status (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .bus(core.stat)
  );
endmodule

// ===== csvr_regs_top_tb.sv
// self-checking bench for the register block, acting as i2c master and audio path
// assumes the package constants and the checker bound to the top module
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module csvr_regs_top_tb;
  import csvr_pkg::*;
  logic clk, srst, scl, sda_m, tick, mute, mono, bclk_err, pll_over, pll_lock, pll_en, bck_miss, rstab;
  logic [9:0] ratio;
  logic [3:0] fs_mode, fs_det;
  logic sda_o, sda_oe, left_hiz, right_hiz;
  logic [7:0] vol, d;
  int fail_count = 0;
  int checks = 0;
  // pulled-up bus: low when either party pulls
  wire sda = sda_m & ~(sda_oe & ~sda_o);
  csvr_regs_top dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .FS_TICK_I(tick), .MUTE_REQ_I(mute), .BRIDGED_MONO_MODE_I(mono),
    .BCLK_RATE_ERR_I(bclk_err), .PLL_OVERRATE_I(pll_over), .PLL_LOCKED_I(pll_lock), .PLL_ENABLED_I(pll_en),
    .BCK_MISSING_I(bck_miss), .BCK_RATIO_I(ratio), .BCK_RATIO_STABLE_I(rstab), .FS_MODE_I(fs_mode),
    .FS_DETECTED_I(fs_det), .LEFT_HIZ_O(left_hiz), .RIGHT_HIZ_O(right_hiz), .VOLUME_CODE_O(vol));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // all stimulus moves 1 ns after a rising edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one bus bit: 8 clocks low, 8 high, sampled mid-high
  task automatic xbit(input logic b, output logic r);
    sda_m = b;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(4);
    r = sda;
    wait_clk(4);
    scl = 1'b0;
  endtask
  task automatic start_c();
    sda_m = 1'b1;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(8);
    sda_m = 1'b0;
    wait_clk(8);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(8);
    sda_m = 1'b1;
    wait_clk(8);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, r);
    `CHK(r, 1'b0)
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    start_c();
    wbyte({DEV_ADDR_DEFAULT, 1'b0});
    wbyte(a);
    wbyte(v);
    stop_c();
  endtask
  // pointer write, repeated start, one byte read with nack
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    logic r;
    start_c();
    wbyte({DEV_ADDR_DEFAULT, 1'b0});
    wbyte(a);
    start_c();
    wbyte({DEV_ADDR_DEFAULT, 1'b1});
    for (int i = 7; i >= 0; i--) xbit(1'b1, v[i]);
    xbit(1'b1, r);
    stop_c();
  endtask
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset_vals();
    `CHK({left_hiz, right_hiz, vol}, {2'b00, 8'h30})
    reg_rd(ADDR_HIZ_FORCE, d);
    `CHK(d, 8'h01)
    reg_rd(ADDR_VOLUME, d);
    `CHK(d, 8'h30)
    reg_rd(ADDR_RAMP_CFG, d);
    `CHK(d, 8'h33)
    reg_rd(8'h41, d); // unmapped offset reads zero
    `CHK(d, 8'h00)
  endtask
  task automatic t_hiz();
    reg_wr(ADDR_HIZ_FORCE, 8'h18);
    `CHK({left_hiz, right_hiz}, 2'b11)
    mono = 1'b1;
    wait_clk(3);
    `CHK({left_hiz, right_hiz}, 2'b00)
    mono = 1'b0;
    wait_clk(12);
    `CHK({left_hiz, right_hiz}, 2'b11)
    reg_wr(ADDR_HIZ_FORCE, 8'h10);
    `CHK({left_hiz, right_hiz}, 2'b10)
    reg_wr(ADDR_HIZ_FORCE, 8'h00);
    `CHK({left_hiz, right_hiz}, 2'b00)
    reg_rd(ADDR_HIZ_FORCE, d);
    `CHK(d, 8'h00)
  endtask
  // drives detector levels, expects the live flags with bits 7:6 left at zero
  task automatic st_chk(input logic be, po, pl, pe, bm, input logic [9:0] r, input logic rs,
                        input logic [3:0] fm, fd);
    logic [7:0] e;
    {bclk_err, pll_over, pll_lock, pll_en, bck_miss, ratio, rstab, fs_mode, fs_det} = {be, po, pl, pe, bm, r,
      rs, fm, fd};
    e = {2'b00, be, po, pl & pe, bm, rs && r >= 10'd32 && r <= 10'd512, (fm == 4'h0) ? fd != 4'h0 : fm != fd};
    wait_clk(3);
    reg_rd(ADDR_CLK_FLAGS, d);
    `CHK(d, e)
  endtask
  task automatic t_status();
    st_chk(1, 0, 1, 0, 0, 10'd31, 1, 4'h0, 4'h0);
    st_chk(0, 1, 1, 1, 1, 10'd32, 1, 4'h0, 4'h9);
    st_chk(1, 0, 0, 1, 0, 10'd512, 1, 4'h9, 4'h9);
    st_chk(0, 0, 1, 1, 0, 10'd513, 1, 4'h9, 4'h6);
    st_chk(0, 0, 1, 1, 0, 10'd64, 0, 4'h6, 4'h0);
  endtask
  task automatic tick_chk(input int n, input logic [7:0] e);
    repeat (n) begin
      tick = 1'b1;
      wait_clk(1);
      tick = 1'b0;
      wait_clk(2);
    end
    `CHK(vol, e)
  endtask
  task automatic t_ramp();
    reg_wr(ADDR_RAMP_CFG, 8'h00); // every tick, 4 dB steps
    reg_wr(ADDR_VOLUME, 8'h44);
    `CHK(vol, 8'h30)
    tick_chk(1, 8'h38);
    tick_chk(1, 8'h40);
    tick_chk(1, 8'h44);
    tick_chk(1, 8'h44);
    reg_wr(ADDR_RAMP_CFG, 8'h09); // up: every 4th tick, 2 dB steps
    reg_wr(ADDR_VOLUME, 8'h3C);
    tick_chk(3, 8'h44);
    tick_chk(1, 8'h40);
    tick_chk(4, 8'h3C);
    reg_wr(ADDR_RAMP_CFG, 8'h70); // down: every 2nd tick, 0.5 dB steps
    reg_wr(ADDR_VOLUME, 8'h3E);
    tick_chk(1, 8'h3C);
    tick_chk(1, 8'h3D);
    tick_chk(2, 8'h3E);
    reg_wr(ADDR_RAMP_CFG, 8'hCC); // both directions jump
    mute = 1'b1;
    wait_clk(6);
    `CHK(vol, VOL_MUTE_CODE)
    mute = 1'b0;
    wait_clk(6);
    `CHK(vol, 8'h3E)
    reg_wr(ADDR_RAMP_CFG, 8'hA6); // down: every 4th tick, 1 dB; up: every 2nd tick, 1 dB
    reg_wr(ADDR_VOLUME, 8'h41);
    tick_chk(3, 8'h3E);
    tick_chk(1, 8'h40);
    tick_chk(4, 8'h41);
    reg_wr(ADDR_VOLUME, 8'h3E);
    tick_chk(1, 8'h41);
    tick_chk(1, 8'h3F);
    tick_chk(2, 8'h3E);
  endtask
  // watchdog: full run needs about 13k cycles, so 40k cycles means a hang
  initial begin
    #400000;
    fail_count++;
    results();
  end
  initial begin
    {srst, scl, sda_m, tick, mute, mono} = 6'b111000;
    {bclk_err, pll_over, pll_lock, pll_en, bck_miss, ratio, rstab, fs_mode, fs_det} = '0;
    wait_clk(10);
    srst = 1'b0;
    wait_clk(4);
    t_reset_vals();
    t_hiz();
    t_status();
    t_ramp();
    results();
  end
endmodule

// ===== csvr_vol_ramp.sv
// volume ramp engine: walks the live code toward the target in sample periods
// assumes fs_tick is a one-cycle pulse per sample period on the core clock
`timescale 1ns/1ps
module csvr_vol_ramp
  import csvr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  csvr_core_if.ramp bus
);
  logic [7:0] cur_reg, cur_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [1:0] down_ivl, down_inc, up_ivl, up_inc;
  logic [8:0] sum_down, stepped_up;

  // interval code to ticks-per-update minus one
  function automatic logic [1:0] ivl_last(input logic [1:0] code);
    ivl_last = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
  endfunction
  // step code to volume codes: 4, 2, 1, 0.5 dB
  function automatic logic [8:0] inc_codes(input logic [1:0] code);
    inc_codes = 9'h008 >> code;
  endfunction

  assign down_ivl = bus.ramp_cfg[DOWN_IVL_LSB +: 2];
  assign down_inc = bus.ramp_cfg[DOWN_INC_LSB +: 2];
  assign up_ivl = bus.ramp_cfg[UP_IVL_LSB +: 2];
  assign up_inc = bus.ramp_cfg[UP_INC_LSB +: 2];
  assign sum_down = {1'b0, cur_reg} + inc_codes(down_inc);
  assign stepped_up = {1'b0, cur_reg} - inc_codes(up_inc);
  assign bus.cur_code = cur_reg;

  // higher code is lower gain, so ramp down means counting the code up
  always_comb begin
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    if (cur_reg < bus.target_code) begin
      if (down_ivl == IVL_JUMP) begin
        cur_next = bus.target_code;
        cnt_next = 2'h0;
      end else if (bus.fs_tick) begin
        if (cnt_reg >= ivl_last(down_ivl)) begin
          cnt_next = 2'h0;
          // clamp so the last step lands on the target
          cur_next = (sum_down >= {1'b0, bus.target_code}) ? bus.target_code : sum_down[7:0];
        end else begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
    end else if (cur_reg > bus.target_code) begin
      if (up_ivl == IVL_JUMP) begin
        cur_next = bus.target_code;
        cnt_next = 2'h0;
      end else if (bus.fs_tick) begin
        if (cnt_reg >= ivl_last(up_ivl)) begin
          cnt_next = 2'h0;
          // underflow shows as bit 8 and is clamped as well
          cur_next = (stepped_up[8] || stepped_up[7:0] <= bus.target_code) ?
                     bus.target_code : stepped_up[7:0];
        end else begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
    end else begin
      cnt_next = 2'h0;
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cur_reg <= RST_VOLUME;
      cnt_reg <= 2'h0;
    end else begin
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
